/* File: cdau_top.sv */
// Avalon-MM wrapper with accumulator, flags, data memory and watchdog
`timescale 1ns/1ps

// Behaviour
// - Invert memory byte, write back to memory
// - Invert memory byte into accumulator
// - Invert-to-accumulator leaves memory byte untouched
// - Both inverts update only the zero flag
// - Low nibble above nine or half-carry adds 6
// - High nibble above nine or carry adds 60H
// - Correction 00/06/60/66H, result to memory
// - Decimal adjust may only set carry
// - Watchdog kick drives powerdown flag to zero unless SLEEP_EVENT is high that cycle
// - Watchdog kick clears count; timeout and powerdown too unless TIMEOUT_EVENT or SLEEP_EVENT sets them
module cdau_top
  import cdau_pkg::*;
(
  input  wire logic              CLOCK,
  input  wire logic              RESET_N,
  input  wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input  wire logic              AVS_READ,
  input  wire logic              AVS_WRITE,
  input  wire logic [DATA_W-1:0] AVS_WRITEDATA,
  input  wire logic [3:0]        AVS_BYTEENABLE,
  output logic      [DATA_W-1:0] AVS_READDATA,
  output logic                   AVS_WAITREQUEST,
  input  wire logic              TIMEOUT_EVENT,
  input  wire logic              SLEEP_EVENT,
  output logic                   TIMEOUT_FLAG,
  output logic                   POWERDOWN_FLAG
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0]        accum;
  logic [ST_W-1:0]   status;
  logic [WDOG_W-1:0] wdog_count;
  logic [7:0]        mem [MEM_DEPTH];
  logic [2:0]        last_op;
  logic              ack;
  logic [DATA_W-1:0] rdata;

  logic [7:0]        next_accum;
  logic [ST_W-1:0]   next_status;
  logic [WDOG_W-1:0] next_wdog_count;
  logic [7:0]        next_mem [MEM_DEPTH];
  logic [2:0]        next_last_op;
  logic              next_ack;
  logic [DATA_W-1:0] next_rdata;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // Every access takes one wait state; read data is registered in it
  logic              req;
  logic              commit;
  logic              wr_low;
  logic              hit_mem;
  logic [MEM_AW-1:0] bus_idx;
  logic [2:0]        cmd_op;
  logic [MEM_AW-1:0] cmd_idx;

  // Data memory sits where the top address bit is set, word aligned
  function automatic logic in_mem_window(input logic [ADDR_W-1:0] a);
    return (a[ADDR_W-1] == OFF_MEM[ADDR_W-1]) && (a[1:0] == 2'b00);
  endfunction

  assign req             = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack;
  assign commit          = req & ack;
  assign wr_low          = commit & AVS_WRITE & AVS_BYTEENABLE[0];
  assign hit_mem         = in_mem_window(AVS_ADDRESS);
  assign bus_idx         = AVS_ADDRESS[MEM_AW+1:2];
  assign cmd_op          = AVS_WRITEDATA[CMD_OP_LSB +: CMD_OP_W];
  assign cmd_idx         = AVS_WRITEDATA[CMD_IDX_LSB +: MEM_AW];
  assign AVS_READDATA    = rdata;
  assign TIMEOUT_FLAG    = status[ST_TIMEOUT];
  assign POWERDOWN_FLAG  = status[ST_PDOWN];

  // ****************************************************************
  // Execution unit
  // ****************************************************************
  logic       start;
  logic [7:0] alu_result;
  logic       alu_mem_we;
  logic       alu_acc_we;
  logic       alu_zero_we;
  logic       alu_zero;
  logic       alu_carry;

  assign start = wr_low & (AVS_ADDRESS == OFF_CMD);

  cdau_alu u_alu (
    .op         (start ? cmd_op : OP_NONE),
    .acc        (accum),
    .mem        (mem[cmd_idx]),
    .carry      (status[ST_CARRY]),
    .half_carry (status[ST_HALF]),
    .result     (alu_result),
    .mem_we     (alu_mem_we),
    .acc_we     (alu_acc_we),
    .zero_we    (alu_zero_we),
    .zero       (alu_zero),
    .carry_out  (alu_carry)
  );

  // ****************************************************************
  // Watchdog count
  // ****************************************************************
  // Saturates rather than wraps, so a core that never kicks reads late
  logic kick;

  assign kick = start & (cmd_op == OP_KICK);

  always_comb begin
    if (kick) begin
      next_wdog_count = '0;
    end else if (wdog_count == {WDOG_W{1'b1}}) begin
      next_wdog_count = wdog_count;
    end else begin
      next_wdog_count = wdog_count + {{(WDOG_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      wdog_count <= '0;
    end else begin
      wdog_count <= next_wdog_count;
    end
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    next_ack        = req & ~ack;
    next_rdata      = rdata;
    next_accum      = accum;
    next_status     = status;
    next_last_op    = last_op;
    next_mem        = mem;

    // Read data is captured in the wait cycle, stable at the commit edge
    if (AVS_READ & ~ack) begin
      next_rdata = '0;
      if (hit_mem) begin
        next_rdata[7:0] = mem[bus_idx];
      end else begin
        case (AVS_ADDRESS)
          OFF_CMD:    next_rdata[2:0]        = last_op;
          OFF_ACC:    next_rdata[7:0]        = accum;
          OFF_STATUS: next_rdata[ST_W-1:0]   = status;
          OFF_WDOG:   next_rdata[WDOG_W-1:0] = wdog_count;
          default:    next_rdata             = '0;
        endcase
      end
    end

    // Plain register writes
    if (wr_low) begin
      if (hit_mem) begin
        next_mem[bus_idx] = AVS_WRITEDATA[7:0];
      end else begin
        case (AVS_ADDRESS)
          OFF_ACC:    next_accum  = AVS_WRITEDATA[7:0];
          OFF_STATUS: next_status = AVS_WRITEDATA[ST_W-1:0];
          default:    next_accum  = next_accum;
        endcase
      end
    end

    // Instruction effects
    if (start) begin
      next_last_op = cmd_op;
      if (alu_mem_we) begin
        next_mem[cmd_idx] = alu_result;
      end
      if (alu_acc_we) begin
        next_accum = alu_result;
      end
      if (alu_zero_we) begin
        next_status[ST_ZERO] = alu_zero;
      end
      next_status[ST_CARRY] = alu_carry;
      if (kick) begin
        next_status[ST_TIMEOUT] = 1'b0;
        next_status[ST_PDOWN]   = 1'b0;
      end
    end

    // Hardware events win over any clear in the same cycle
    if (TIMEOUT_EVENT) begin
      next_status[ST_TIMEOUT] = 1'b1;
    end
    if (SLEEP_EVENT) begin
      next_status[ST_PDOWN] = 1'b1;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      ack        <= 1'b0;
      rdata      <= '0;
      accum      <= ACC_RST;
      status     <= STATUS_RST;
      last_op    <= OP_RST;
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem[i] <= MEM_RST;
      end
    end else begin
      ack        <= next_ack;
      rdata      <= next_rdata;
      accum      <= next_accum;
      status     <= next_status;
      last_op    <= next_last_op;
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem[i] <= next_mem[i];
      end
    end
  end

endmodule

/* File: cdau_alu.sv */
// Package of constants and the combinational execution unit
`timescale 1ns/1ps

package cdau_pkg;
  // ****************************************************************
  // Bus and register map
  // ****************************************************************
  localparam int          ADDR_W      = 7;
  localparam int          DATA_W      = 32;
  localparam logic [6:0]  OFF_CMD     = 7'h00;
  localparam logic [6:0]  OFF_ACC     = 7'h04;
  localparam logic [6:0]  OFF_STATUS  = 7'h08;
  localparam logic [6:0]  OFF_WDOG    = 7'h0C;
  localparam logic [6:0]  OFF_MEM     = 7'h40;
  localparam int          MEM_AW      = 4;
  localparam int          MEM_DEPTH   = 16;
  localparam int          WDOG_W      = 16;
  // ****************************************************************
  // Command field layout and opcodes
  // ****************************************************************
  localparam int          CMD_OP_LSB  = 0;
  localparam int          CMD_OP_W    = 3;
  localparam int          CMD_IDX_LSB = 4;
  localparam logic [2:0]  OP_NONE     = 3'h0;
  localparam logic [2:0]  OP_INV_MEM  = 3'h1;
  localparam logic [2:0]  OP_INV_ACC  = 3'h2;
  localparam logic [2:0]  OP_BCD_FIX  = 3'h3;
  localparam logic [2:0]  OP_KICK     = 3'h4;
  // ****************************************************************
  // Status bit positions and reset values
  // ****************************************************************
  localparam int          ST_ZERO     = 0;
  localparam int          ST_CARRY    = 1;
  localparam int          ST_HALF     = 2;
  localparam int          ST_TIMEOUT  = 3;
  localparam int          ST_PDOWN    = 4;
  localparam int          ST_W        = 5;
  localparam logic [4:0]  STATUS_RST  = 5'h00;
  localparam logic [7:0]  ACC_RST     = 8'h00;
  localparam logic [7:0]  MEM_RST     = 8'h00;
  localparam logic [2:0]  OP_RST      = 3'h0;
  // ****************************************************************
  // Decimal adjust constants
  // ****************************************************************
  localparam logic [3:0]  BCD_LIMIT   = 4'h9;
  localparam logic [8:0]  BCD_LOW_FIX = 9'h006;
  localparam logic [8:0]  BCD_HI_FIX  = 9'h060;
  localparam logic [8:0]  BCD_NO_FIX  = 9'h000;
endpackage

module cdau_alu
  import cdau_pkg::*;
(
  input  wire logic [2:0] op,
  input  wire logic [7:0] acc,
  input  wire logic [7:0] mem,
  input  wire logic       carry,
  input  wire logic       half_carry,
  output logic      [7:0] result,
  output logic            mem_we,
  output logic            acc_we,
  output logic            zero_we,
  output logic            zero,
  output logic            carry_out
);

  function automatic logic over_nine(input logic [3:0] nib);
    return nib > BCD_LIMIT;
  endfunction

  logic [8:0] low_adj;
  logic [8:0] full_adj;

  always_comb begin
    low_adj  = {1'b0, acc} + ((over_nine(acc[3:0]) | half_carry) ?
               BCD_LOW_FIX : BCD_NO_FIX);
    // High check follows the low fix so a low carry ripples in
    full_adj = low_adj + ((over_nine(low_adj[7:4]) | low_adj[8] | carry) ?
               BCD_HI_FIX : BCD_NO_FIX);
    result    = 8'h00;
    mem_we    = 1'b0;
    acc_we    = 1'b0;
    zero_we   = 1'b0;
    carry_out = carry;
    case (op)
      OP_INV_MEM: begin
        result  = ~mem;
        mem_we  = 1'b1;
        zero_we = 1'b1;
      end
      OP_INV_ACC: begin
        result  = ~mem;
        acc_we  = 1'b1;
        mem_we  = 1'b0;
        zero_we = 1'b1;
      end
      OP_BCD_FIX: begin
        result    = full_adj[7:0];
        mem_we    = 1'b1;
        carry_out = carry | full_adj[8];
      end
      default: begin
        result = 8'h00;
      end
    endcase
    zero = (result == 8'h00);
  end

endmodule

/* File: cdau_top_asserts.sv */
// Port-level checks of the complement and decimal adjust unit
`timescale 1ns/1ps
module cdau_top_asserts
  import cdau_pkg::*;
(
  input wire logic        CLOCK,
  input wire logic        RESET_N,
  input wire logic [6:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0]  AVS_BYTEENABLE,
  input wire logic        AVS_WAITREQUEST,
  input wire logic        TIMEOUT_EVENT,
  input wire logic        SLEEP_EVENT,
  input wire logic        TIMEOUT_FLAG,
  input wire logic        POWERDOWN_FLAG
);
  // ****************************************************************
  // Command commit decode
  // ****************************************************************
  logic       cmt;
  logic [2:0] op;
  logic       quiet;
  assign cmt = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == OFF_CMD
               && AVS_BYTEENABLE[0];
  assign op = AVS_WRITEDATA[2:0];
  // Events win over the kick, so they are kept out of the antecedents
  assign quiet = !TIMEOUT_EVENT && !SLEEP_EVENT;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  chk_kick_timeout: assert property (
    cmt && op == OP_KICK && !TIMEOUT_EVENT |=> !TIMEOUT_FLAG)
    else $error("kick left timeout flag set");
  chk_kick_pdown: assert property (
    cmt && op == OP_KICK && !SLEEP_EVENT |=> !POWERDOWN_FLAG)
    else $error("kick left powerdown flag set");
  chk_invert_flags: assert property (
    cmt && (op == OP_INV_MEM || op == OP_INV_ACC) && quiet
    |=> $stable({TIMEOUT_FLAG, POWERDOWN_FLAG}))
    else $error("invert changed a watchdog flag");
  chk_bcd_flags: assert property (
    cmt && op == OP_BCD_FIX && quiet
    |=> $stable({TIMEOUT_FLAG, POWERDOWN_FLAG}))
    else $error("decimal adjust changed a watchdog flag");
  chk_pdown_hold: assert property (
    !SLEEP_EVENT && !(AVS_WRITE && !AVS_WAITREQUEST)
    |=> !$rose(POWERDOWN_FLAG))
    else $error("powerdown flag rose without cause");
  chk_event_sets: assert property (
    TIMEOUT_EVENT |=> TIMEOUT_FLAG)
    else $error("timeout event not recorded");
  chk_wait_one: assert property (
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("more than one wait state");
  chk_idle_free: assert property (
    !AVS_READ && !AVS_WRITE |-> !AVS_WAITREQUEST)
    else $error("wait request while idle");
endmodule

/* File: cdau_top_tb.sv */
// Self-checking bench for the complement and decimal adjust unit
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module cdau_top_tb;
  import cdau_pkg::*;
  logic        CLOCK = 1'h0;
  logic        RESET_N = 1'h0;
  logic [6:0]  AVS_ADDRESS = 7'h00;
  logic        AVS_READ = 1'h0;
  logic        AVS_WRITE = 1'h0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [3:0]  AVS_BYTEENABLE = 4'hF;
  logic [31:0] AVS_READDATA;
  logic        AVS_WAITREQUEST;
  logic        TIMEOUT_EVENT = 1'h0;
  logic        SLEEP_EVENT = 1'h0;
  logic        TIMEOUT_FLAG;
  logic        POWERDOWN_FLAG;
  logic [31:0] r;
  int          err_count = 0;
  int          compares = 0;
  int          cyc = 0;
  // Decimal adjust cases: accumulator, {carry, half}, result, carry out
  logic [7:0]  bacc[7] = '{8'h45, 8'h4B, 8'h43, 8'hA3, 8'h23, 8'h9A, 8'h99};
  logic [1:0]  bfl[7] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h2, 2'h0, 2'h3};
  logic [7:0]  bres[7] = '{8'h45, 8'h51, 8'h49, 8'h03, 8'h83, 8'h00, 8'hFF};
  logic [6:0]  bcy = 7'h78;
  cdau_top u_cdau_top (
    .CLOCK           (CLOCK),
    .RESET_N         (RESET_N),
    .AVS_ADDRESS     (AVS_ADDRESS),
    .AVS_READ        (AVS_READ),
    .AVS_WRITE       (AVS_WRITE),
    .AVS_WRITEDATA   (AVS_WRITEDATA),
    .AVS_BYTEENABLE  (AVS_BYTEENABLE),
    .AVS_READDATA    (AVS_READDATA),
    .AVS_WAITREQUEST (AVS_WAITREQUEST),
    .TIMEOUT_EVENT   (TIMEOUT_EVENT),
    .SLEEP_EVENT     (SLEEP_EVENT),
    .TIMEOUT_FLAG    (TIMEOUT_FLAG),
    .POWERDOWN_FLAG  (POWERDOWN_FLAG)
  );
  always #25 CLOCK = ~CLOCK;
  // ****************************************************************
  // Avalon-MM master tasks
  // ****************************************************************
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= 1'h1;
    do @(posedge CLOCK); while (AVS_WAITREQUEST !== 1'h0);
    AVS_WRITE <= 1'h0;
  endtask
  task automatic rd(input logic [6:0] a);
    @(posedge CLOCK);
    AVS_ADDRESS <= a;
    AVS_READ <= 1'h1;
    do @(posedge CLOCK); while (AVS_WAITREQUEST !== 1'h0);
    r = AVS_READDATA;
    AVS_READ <= 1'h0;
  endtask
  task automatic rc(input logic [6:0] a, input logic [31:0] e, string n);
    rd(a);
    `CHK(n, e, r)
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // A hung handshake ends the run here
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      close_out();
    end
  end
  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    repeat (4) @(posedge CLOCK);
    RESET_N <= 1'h1;
    rc(7'h10, 32'h0, "unmapped");
    wr(7'h4C, 32'h5A);
    wr(7'h08, 32'h1E);
    wr(7'h00, 32'h31);
    rc(7'h4C, 32'hA5, "inv mem");
    rc(7'h08, 32'h1E, "inv flags");
    wr(7'h4C, 32'hFF);
    wr(7'h00, 32'h31);
    rc(7'h08, 32'h1F, "inv zero");
    wr(7'h54, 32'hFF);
    wr(7'h04, 32'h33);
    wr(7'h08, 32'h06);
    wr(7'h00, 32'h52);
    rc(7'h04, 32'h0, "inv acc");
    rc(7'h54, 32'hFF, "inv keep");
    rc(7'h08, 32'h07, "inv acc flags");
    $display("invert tests done");
    for (int i = 0; i < 7; i++) begin
      wr(7'h04, {24'h0, bacc[i]});
      wr(7'h08, {27'h0, 2'h0, bfl[i][0], bfl[i][1], 1'h1});
      wr(7'h00, 32'h73);
      rc(7'h5C, {24'h0, bres[i]}, "bcd mem");
      rc(7'h04, {24'h0, bacc[i]}, "bcd acc");
      r = {27'h0, 2'h0, bfl[i][0], bfl[i][1] | bcy[i], 1'h1};
      rc(7'h08, r, "bcd flags");
    end
    $display("decimal adjust tests done");
    wr(7'h08, 32'h07);
    @(posedge CLOCK);
    TIMEOUT_EVENT <= 1'h1;
    SLEEP_EVENT <= 1'h1;
    @(posedge CLOCK);
    TIMEOUT_EVENT <= 1'h0;
    SLEEP_EVENT <= 1'h0;
    rc(7'h08, 32'h1F, "events");
    wr(7'h00, 32'h04);
    rc(7'h08, 32'h07, "kick flags");
    `CHK("flag pins", 2'h0, {TIMEOUT_FLAG, POWERDOWN_FLAG})
    rd(7'h0C);
    `CHK("wdog", 1'h1, r < 32'h10)
    $display("watchdog kick tests done");
    // Low byte lane off: the command must be ignored
    AVS_BYTEENABLE <= 4'hE;
    wr(7'h00, 32'h71);
    AVS_BYTEENABLE <= 4'hF;
    rc(7'h5C, 32'hFF, "masked cmd mem");
    rc(7'h00, 32'h4, "masked cmd code");
    // Undefined opcode changes nothing but the recorded code
    wr(7'h00, 32'h75);
    rc(7'h5C, 32'hFF, "idle op mem");
    rc(7'h08, 32'h07, "idle op flags");
    rc(7'h00, 32'h5, "idle op code");
    $display("command decode tests done");
    close_out();
  end
endmodule
bind cdau_top cdau_top_asserts u_cdau_top_asserts (
  .CLOCK           (CLOCK),
  .RESET_N         (RESET_N),
  .AVS_ADDRESS     (AVS_ADDRESS),
  .AVS_READ        (AVS_READ),
  .AVS_WRITE       (AVS_WRITE),
  .AVS_WRITEDATA   (AVS_WRITEDATA),
  .AVS_BYTEENABLE  (AVS_BYTEENABLE),
  .AVS_WAITREQUEST (AVS_WAITREQUEST),
  .TIMEOUT_EVENT   (TIMEOUT_EVENT),
  .SLEEP_EVENT     (SLEEP_EVENT),
  .TIMEOUT_FLAG    (TIMEOUT_FLAG),
  .POWERDOWN_FLAG  (POWERDOWN_FLAG)
);
